// >>> bench/ccs_led_model.sv
`timescale 1ns/100ps
// ------------------------------
// status lamps on pulled-up pins
// ------------------------------
module ccs_led_model (
	input  wire logic       a_o,
	input  wire logic       a_oe_n,
	input  wire logic       b_o,
	input  wire logic       b_oe_n,
	input  wire logic       g_o,
	input  wire logic       g_oe_n,
	output logic      [2:0] on
);
	// released pin floats high, lamp dark
	assign on = ~{a_oe_n ? 1'b1 : a_o, b_oe_n ? 1'b1 : b_o, g_oe_n ? 1'b1 : g_o};
endmodule

// >>> bench/tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
	import ccs_pkg::*;
	logic        clk, rst_n, term, below, ovp, vcc, ten, thi, ce_n, rate, at_reg, lowv, temp, ddone;
	logic [3:0]  aw, ar;
	logic [31:0] wd, rd, d, seed;
	logic        awv, wv, bre, arv, rre, awr, wr, bv, arr, rv, pwm, rfast, dcur, drun;
	logic [1:0]  br, rr, r;
	logic        ao, aoe, bo, boe, go, goe;
	logic [2:0]  leds;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          cnt;
	logic        coin, lvl;
	localparam int TICKS = 4;
	ccs_top #(.TICK_CYCLES(TICKS)) uut (
		.CLK_SYS(clk), .RST_N(rst_n), .CMP_TERM_CURRENT(term), .CMP_BELOW_RECHARGE(below),
		.CMP_OVERVOLTAGE(ovp), .CMP_SLEEP_EXIT(vcc), .TIMER_CAPACITOR_IN_EN(ten), .TIMER_CAPACITOR_IN_HIGH(thi),
		.CHARGE_EN_N(ce_n), .CHARGE_RATE_SELECT(rate), .CMP_AT_REGULATION(at_reg), .CMP_BELOW_LOWV(lowv),
		.CMP_TEMP_FAULT(temp), .CMP_BAT_SHORT(1'b0), .DET_DONE(ddone), .DET_ABSENT(1'b0),
		.STATUS_OUT_A_O(ao), .STATUS_OUT_A_OE_N(aoe), .STATUS_OUT_B_O(bo), .STATUS_OUT_B_OE_N(boe),
		.POWER_GOOD_OUT_O(go), .POWER_GOOD_OUT_OE_N(goe), .PWM_EN(pwm), .RATE_FAST(rfast),
		.DETECT_CURRENT_EN(dcur), .BAT_DETECT_RUN(drun), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
		.S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre)
	);
	ccs_led_model lamps (.a_o(ao), .a_oe_n(aoe), .b_o(bo), .b_oe_n(boe), .g_o(go), .g_oe_n(goe), .on(leds));
	// ----------------------------------------
	// bench tasks
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task stop_test;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task tmo(input int n);
		if (n >= 64) begin
			miscompares++;
			$display("[ERR] %0t bus timeout", $time);
			stop_test;
		end
	endtask
	task axw(input logic [3:0] a, input logic [31:0] v);
		int n;
		@(posedge clk);
		aw <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
			if (bv) break;
		end
		r = br;
		bre <= 1'b0;
		tmo(n);
	endtask
	task axr(input logic [3:0] a);
		int n;
		@(posedge clk);
		ar <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
			if (rv) break;
		end
		d = rd;
		r = rr;
		rre <= 1'b0;
		tmo(n);
	endtask
	// lamps a, b, power good from the cycle state
	function logic [2:0] exp_led(input int st);
		return {st inside {2, 3, 4}, st == 5, st != 0};
	endfunction
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// inputs need two sync edges plus state and output edges
	task chk(input int st);
		repeat (6) @(posedge clk);
		axr(REG_STATUS);
		`CHK(d[3:0], st[3:0])
		`CHK(leds, exp_led(st) & {~temp, 2'b11})
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{term, below, ovp, vcc, ten, thi, ce_n, rate, at_reg, lowv, temp, ddone, rst_n} = '0;
		{aw, ar, wd, awv, wv, bre, arv, rre} = '0;
		seed = 32'd98;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		axr(REG_CTRL);
		`CHK(d, 32'h0)
		axr(REG_TLIMIT);
		`CHK(d[25:0], TLIMIT_RST)
		axr(4'h2);
		`CHK(r, RESP_SLERR)
		axw(4'h2, 32'h1);
		`CHK(r, RESP_SLERR)
		axw(REG_TLIMIT, 32'h5);
		chk(0);
		$display("test sleep done");
		vcc <= 1'b1;
		below <= 1'b1;
		chk(3);
		`CHK(pwm, 1'b1)
		repeat (40) @(posedge clk);
		chk(3);
		axr(REG_TIMER);
		`CHK(d, 32'h0)
		at_reg <= 1'b1;
		below <= 1'b0;
		term <= 1'b1;
		chk(4);
		temp <= 1'b1;
		chk(4);
		temp <= 1'b0;
		ten <= 1'b1;
		thi <= 1'b1;
		chk(5);
		$display("test termination done");
		{at_reg, term, lowv, below} <= 4'b0011;
		chk(2);
		`CHK(rfast, 1'b0)
		lowv <= 1'b0;
		thi <= 1'b0;
		repeat (60) @(posedge clk);
		chk(6);
		`CHK(dcur, 1'b1)
		below <= 1'b0;
		chk(6);
		`CHK(dcur, 1'b0)
		below <= 1'b1;
		chk(8);
		`CHK(drun, 1'b1)
		ddone <= 1'b1;
		chk(3);
		ddone <= 1'b0;
		ovp <= 1'b1;
		chk(7);
		`CHK(pwm, 1'b0)
		ovp <= 1'b0;
		$display("test faults done");
		repeat (60) @(posedge clk);
		axw(REG_CTRL, 32'h2);
		repeat (2) @(posedge clk);
		lvl = leds[2];
		// a missing blink runs the first loop to its limit, ends the second at once, and the count check catches it
		for (cnt = 0; cnt < 5000 && leds[2] == lvl; cnt++) @(posedge clk);
		for (cnt = 0; cnt < 5000 && leds[2] != lvl; cnt++) @(posedge clk);
		`CHK(cnt, BLINK_HALF_TICKS * TICKS)
		`CHK(leds[1:0], 2'b01)
		$display("test blink done");
		ce_n <= 1'b1;
		chk(1);
		`CHK(pwm, 1'b0)
		ce_n <= 1'b0;
		chk(3);
		$display("test enable done");
		axw(REG_CTRL, 32'h1);
		for (int i = 0; i < 8; i++) begin
			// expectation from the drawn value, not the not-yet-updated pin
			coin = 1'(rnd());
			rate <= coin;
			chk(coin ? 3 : 2);
			`CHK(rfast, coin)
		end
		at_reg <= 1'b1;
		term <= 1'b1;
		chk(4);
		ovp <= 1'b1;
		chk(7);
		`CHK(pwm, 1'b0)
		$display("test host done");
		vcc <= 1'b0;
		chk(0);
		`CHK(pwm, 1'b0)
		stop_test;
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("[ERR] %0t run timeout", $time);
		stop_test;
	end
endmodule

// >>> src/ccs_axil.sv
`timescale 1ns/100ps
module ccs_axil
	import ccs_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	ccs_reg_if.regs                rif
);
	logic                aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic [ADDR_W-1:0]   awaddr_r, awaddr_nxt;
	logic [31:0]         wdata_r, wdata_nxt, rdata_nxt, m;
	logic [3:0]          wstrb_r, wstrb_nxt;
	logic                bvalid_nxt, rvalid_nxt;
	logic [1:0]          bresp_nxt, rresp_nxt;
	logic [CTRL_W-1:0]   ctrl_r, ctrl_nxt;
	logic [TLIMIT_W-1:0] tlimit_r, tlimit_nxt;
	logic                aw_take, w_take, do_wr;
	logic [ADDR_W-1:0]   a;
	logic [31:0]         d;
	logic [3:0]          s;

	// byte-lane merge of a write into a register word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) merge[8*i +: 8] = nw[8*i +: 8];
		end
	endfunction

	assign awready = !aw_have_r && !bvalid;
	assign wready  = !w_have_r && !bvalid;
	assign arready = !rvalid;
	assign rif.host_mode  = ctrl_r[CTRL_HOST];
	assign rif.alt_status = ctrl_r[CTRL_ALT];
	assign rif.tlimit     = tlimit_r;

	always_comb begin
		aw_take     = awvalid && awready;
		w_take      = wvalid && wready;
		a           = aw_take ? awaddr : awaddr_r;
		d           = w_take ? wdata : wdata_r;
		s           = w_take ? wstrb : wstrb_r;
		do_wr       = (aw_have_r || aw_take) && (w_have_r || w_take);
		aw_have_nxt = (aw_have_r || aw_take) && !do_wr;
		w_have_nxt  = (w_have_r || w_take) && !do_wr;
		awaddr_nxt  = a;
		wdata_nxt   = d;
		wstrb_nxt   = s;
		bvalid_nxt  = bvalid && !bready;
		bresp_nxt   = bresp;
		rvalid_nxt  = rvalid && !rready;
		rdata_nxt   = rdata;
		rresp_nxt   = rresp;
		ctrl_nxt    = ctrl_r;
		tlimit_nxt  = tlimit_r;
		m           = 32'h0;
		if (do_wr) begin
			bvalid_nxt = 1'b1;
			bresp_nxt  = RESP_OKAY;
			case (a)
				REG_CTRL: begin
					m        = merge({{(32-CTRL_W){1'b0}}, ctrl_r}, d, s);
					ctrl_nxt = m[CTRL_W-1:0];
				end
				REG_TLIMIT: begin
					m          = merge({{(32-TLIMIT_W){1'b0}}, tlimit_r}, d, s);
					tlimit_nxt = m[TLIMIT_W-1:0];
				end
				REG_STATUS, REG_TIMER: bresp_nxt = RESP_OKAY;
				default: bresp_nxt = RESP_SLERR;
			endcase
		end
		if (arvalid && arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = RESP_OKAY;
			case (araddr)
				REG_CTRL:   rdata_nxt = {{(32-CTRL_W){1'b0}}, ctrl_r};
				REG_TLIMIT: rdata_nxt = {{(32-TLIMIT_W){1'b0}}, tlimit_r};
				REG_STATUS: rdata_nxt = {{(32-STAT_W){1'b0}}, rif.status};
				REG_TIMER:  rdata_nxt = {{(32-TLIMIT_W){1'b0}}, rif.timer};
				default: begin
					rdata_nxt = 32'h0;
					rresp_nxt = RESP_SLERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= 32'h0;
			wstrb_r   <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= RESP_OKAY;
			rvalid    <= 1'b0;
			rdata     <= 32'h0;
			rresp     <= RESP_OKAY;
			ctrl_r    <= CTRL_RST;
			tlimit_r  <= TLIMIT_RST;
		end else begin
			aw_have_r <= aw_have_nxt;
			w_have_r  <= w_have_nxt;
			awaddr_r  <= awaddr_nxt;
			wdata_r   <= wdata_nxt;
			wstrb_r   <= wstrb_nxt;
			bvalid    <= bvalid_nxt;
			bresp     <= bresp_nxt;
			rvalid    <= rvalid_nxt;
			rdata     <= rdata_nxt;
			rresp     <= rresp_nxt;
			ctrl_r    <= ctrl_nxt;
			tlimit_r  <= tlimit_nxt;
		end
	end
endmodule

// >>> src/ccs_pkg.sv
package ccs_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ          = 40;
	localparam int TICK_US          = 1000;
	localparam int TICK_CYC         = TICK_US * CLK_MHZ;
	localparam int BLINK_PERIOD_MS  = 2000;
	localparam int BLINK_HALF_TICKS = BLINK_PERIOD_MS * 1000 / TICK_US / 2;
	// safety timer limit in ticks, default five hours
	localparam int                  TLIMIT_W   = 26;
	localparam logic [TLIMIT_W-1:0] TLIMIT_RST = 26'h112A880;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int                ADDR_W     = 4;
	localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
	localparam logic [ADDR_W-1:0] REG_TLIMIT = 4'h4;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
	localparam logic [ADDR_W-1:0] REG_TIMER  = 4'hC;
	localparam int                CTRL_W     = 2;
	localparam int                CTRL_HOST  = 0;
	localparam int                CTRL_ALT   = 1;
	localparam logic [CTRL_W-1:0] CTRL_RST   = 2'h0;
	localparam int                STAT_W     = 9;
	localparam logic [1:0]        RESP_OKAY  = 2'h0;
	localparam logic [1:0]        RESP_SLERR = 2'h2;
	localparam int                IN_W       = 14;
	// ----------------------------------------
	// charge cycle states
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_SLEEP, ST_IDLE, ST_PRECHG, ST_FAST, ST_VREG, ST_DONE, ST_TFAULT, ST_OVP, ST_DETECT
	} ccs_state_t;
endpackage

// >>> src/ccs_reg_if.sv
`timescale 1ns/100ps
interface ccs_reg_if;
	import ccs_pkg::*;
	logic                host_mode;
	logic                alt_status;
	logic [TLIMIT_W-1:0] tlimit;
	logic [STAT_W-1:0]   status;
	logic [TLIMIT_W-1:0] timer;
	modport regs (output host_mode, alt_status, tlimit, input status, timer);
	modport core (input host_mode, alt_status, tlimit, output status, timer);
endinterface

// >>> src/ccs_sync.sv
`timescale 1ns/100ps
module ccs_sync #(
	parameter int W = 1
)(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	always_comb begin
		meta_nxt = d;
		q_nxt    = meta_r;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= meta_nxt;
			q      <= q_nxt;
		end
	end
endmodule

// >>> src/ccs_top.sv
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
module ccs_top
	import ccs_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
)(
	input  wire logic              CLK_SYS,
	input  wire logic              RST_N,
	input  wire logic              CMP_TERM_CURRENT,
	input  wire logic              CMP_BELOW_RECHARGE,
	input  wire logic              CMP_OVERVOLTAGE,
	input  wire logic              CMP_SLEEP_EXIT,
	input  wire logic              TIMER_CAPACITOR_IN_EN,
	input  wire logic              TIMER_CAPACITOR_IN_HIGH,
	input  wire logic              CHARGE_EN_N,
	input  wire logic              CHARGE_RATE_SELECT,
	input  wire logic              CMP_AT_REGULATION,
	input  wire logic              CMP_BELOW_LOWV,
	input  wire logic              CMP_TEMP_FAULT,
	input  wire logic              CMP_BAT_SHORT,
	input  wire logic              DET_DONE,
	input  wire logic              DET_ABSENT,
	output logic                   STATUS_OUT_A_O,
	output logic                   STATUS_OUT_A_OE_N,
	output logic                   STATUS_OUT_B_O,
	output logic                   STATUS_OUT_B_OE_N,
	output logic                   POWER_GOOD_OUT_O,
	output logic                   POWER_GOOD_OUT_OE_N,
	output logic                   PWM_EN,
	output logic                   RATE_FAST,
	output logic                   DETECT_CURRENT_EN,
	output logic                   BAT_DETECT_RUN,
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	output logic [1:0]             S_AXI_BRESP,
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	output logic [31:0]            S_AXI_RDATA,
	output logic [1:0]             S_AXI_RRESP,
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	ccs_reg_if rif ();

	logic [IN_W-1:0]     sync_q;
	logic                term_s, rch_s, ovp_s, vcc_s, ttc_en_s, ttc_high_s, ce_n_s, charge_rate_select_s;
	logic                at_vreg_s, lowv_s, temp_s, short_s, det_done_s, det_absent_s;
	logic                ttc_en_d_r, ce_n_d_r, ttc_rise, ce_fall;
	logic                host, alt, charging, suspend, timer_en, term_en, timeout, start;
	ccs_state_t          state_r, state_nxt;
	logic                seen_high_r, seen_high_nxt, pre_fault_r, pre_fault_nxt;
	logic [TLIMIT_W-1:0] timer_r, timer_nxt;
	logic [31:0]         tick_cnt_r, tick_cnt_nxt;
	logic [15:0]         half_cnt_r, half_cnt_nxt;
	logic                tick_r, tick_nxt, blink_r, blink_nxt, blink_fault;
	logic                a_on_r, a_on_nxt, b_on_r, b_on_nxt, pg_r, pg_nxt;
	logic                pwm_r, pwm_nxt, fast_r, fast_nxt, dcur_r, dcur_nxt, drun_r, drun_nxt;

	// first phase of a fresh cycle; host mode follows the rate input
	function automatic ccs_state_t phase_of(input logic h, input logic cm, input logic vr, input logic lv);
		if (vr) phase_of = ST_VREG;
		else if (h) phase_of = cm ? ST_FAST : ST_PRECHG;
		else phase_of = lv ? ST_PRECHG : ST_FAST;
	endfunction

	// ----------------------------------------
	// inputs and register bus
	// ----------------------------------------
	ccs_sync #(.W(IN_W)) u_sync (
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.d     ({DET_ABSENT, DET_DONE, CMP_BAT_SHORT, CMP_TEMP_FAULT, CMP_BELOW_LOWV, CMP_AT_REGULATION,
		         CHARGE_RATE_SELECT, CHARGE_EN_N, TIMER_CAPACITOR_IN_HIGH, TIMER_CAPACITOR_IN_EN,
		         CMP_SLEEP_EXIT, CMP_OVERVOLTAGE, CMP_BELOW_RECHARGE, CMP_TERM_CURRENT}),
		.q     (sync_q)
	);
	assign {det_absent_s, det_done_s, short_s, temp_s, lowv_s, at_vreg_s, charge_rate_select_s, ce_n_s,
	        ttc_high_s, ttc_en_s, vcc_s, ovp_s, rch_s, term_s} = sync_q;

	ccs_axil u_axil (
		.clk     (CLK_SYS),
		.rst_n   (RST_N),
		.awaddr  (S_AXI_AWADDR),
		.awvalid (S_AXI_AWVALID),
		.awready (S_AXI_AWREADY),
		.wdata   (S_AXI_WDATA),
		.wstrb   (S_AXI_WSTRB),
		.wvalid  (S_AXI_WVALID),
		.wready  (S_AXI_WREADY),
		.bresp   (S_AXI_BRESP),
		.bvalid  (S_AXI_BVALID),
		.bready  (S_AXI_BREADY),
		.araddr  (S_AXI_ARADDR),
		.arvalid (S_AXI_ARVALID),
		.arready (S_AXI_ARREADY),
		.rdata   (S_AXI_RDATA),
		.rresp   (S_AXI_RRESP),
		.rvalid  (S_AXI_RVALID),
		.rready  (S_AXI_RREADY),
		.rif     (rif)
	);

	assign host = rif.host_mode;
	assign alt  = rif.alt_status;
	assign rif.status = {pg_r, suspend, state_r == ST_OVP, state_r == ST_TFAULT, pre_fault_r, state_r};
	assign rif.timer  = timer_r;

	// ----------------------------------------
	// charge cycle sequencer
	// ----------------------------------------
	assign ttc_rise = ttc_en_s && !ttc_en_d_r;
	assign ce_fall  = !ce_n_s && ce_n_d_r;
	assign charging = state_r == ST_PRECHG || state_r == ST_FAST || state_r == ST_VREG;
	// suspend holds the timer instead of clearing it
	assign suspend  = charging && temp_s;
	assign timer_en = !host && ttc_en_s && !ttc_high_s;
	assign term_en  = !host && ttc_en_s;
	assign timeout  = charging && timer_en && timer_r >= rif.tlimit;

	always_comb begin
		state_nxt     = state_r;
		seen_high_nxt = 1'b0;
		pre_fault_nxt = pre_fault_r;
		start         = 1'b0;
		if (!vcc_s) state_nxt = ST_SLEEP;
		else if (ce_n_s) state_nxt = ST_IDLE;
		else if (ovp_s) state_nxt = ST_OVP;
		else if (ce_fall) start = 1'b1;
		else begin
			case (state_r)
				ST_SLEEP, ST_IDLE: begin
					if (rch_s) start = 1'b1;
					else state_nxt = ST_DONE;
				end
				ST_OVP: if (rch_s) start = 1'b1;
				ST_DONE: if (rch_s) start = 1'b1;
				ST_TFAULT: begin
					seen_high_nxt = seen_high_r || !rch_s;
					if (seen_high_r && rch_s) state_nxt = ST_DETECT;
				end
				ST_DETECT: if (det_done_s && !det_absent_s) start = 1'b1;
				ST_PRECHG, ST_FAST, ST_VREG: begin
					if (ttc_rise && !host) start = 1'b1;
					else if (timeout) begin
						state_nxt     = ST_TFAULT;
						pre_fault_nxt = state_r == ST_PRECHG;
					end else if (state_r == ST_VREG) begin
						if (term_s && term_en) state_nxt = ST_DONE;
					end else if (host || state_r == ST_PRECHG) state_nxt = phase_of(host, charge_rate_select_s, at_vreg_s, lowv_s);
					else if (at_vreg_s) state_nxt = ST_VREG;
				end
				default: state_nxt = ST_SLEEP;
			endcase
		end
		if (start) state_nxt = phase_of(host, charge_rate_select_s, at_vreg_s, lowv_s);
	end

	always_comb begin
		timer_nxt = timer_r;
		if (start || ttc_rise || !charging) timer_nxt = '0;
		else if (timer_en && !suspend && tick_r) timer_nxt = timer_r + 1'b1;
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			state_r     <= ST_SLEEP;
			seen_high_r <= 1'b0;
			pre_fault_r <= 1'b0;
			timer_r     <= '0;
			ttc_en_d_r  <= 1'b0;
			ce_n_d_r    <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			seen_high_r <= seen_high_nxt;
			pre_fault_r <= pre_fault_nxt;
			timer_r     <= timer_nxt;
			ttc_en_d_r  <= ttc_en_s;
			ce_n_d_r    <= ce_n_s;
		end
	end

	// ----------------------------------------
	// tick and blink dividers
	// ----------------------------------------
	// equal halves from the tick divider
	always_comb begin
		tick_nxt     = tick_cnt_r == 32'(TICK_CYCLES - 1);
		tick_cnt_nxt = tick_nxt ? 32'h0 : tick_cnt_r + 32'h1;
		half_cnt_nxt = half_cnt_r;
		blink_nxt    = blink_r;
		if (tick_r) begin
			if (half_cnt_r == 16'(BLINK_HALF_TICKS - 1)) begin
				half_cnt_nxt = 16'h0;
				blink_nxt    = !blink_r;
			end else half_cnt_nxt = half_cnt_r + 16'h1;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			tick_cnt_r <= 32'h0;
			tick_r     <= 1'b0;
			half_cnt_r <= 16'h0;
			blink_r    <= 1'b0;
		end else begin
			tick_cnt_r <= tick_cnt_nxt;
			tick_r     <= tick_nxt;
			half_cnt_r <= half_cnt_nxt;
			blink_r    <= blink_nxt;
		end
	end

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	always_comb begin
		blink_fault = (charging && (suspend || short_s)) || state_r == ST_TFAULT;
		if (alt) a_on_nxt = blink_fault ? blink_r : charging;
		else a_on_nxt = charging && !suspend;
		b_on_nxt = state_r == ST_DONE;
		pg_nxt   = state_r != ST_SLEEP;
		pwm_nxt  = charging && !suspend;
		fast_nxt = state_r == ST_FAST || state_r == ST_VREG;
		dcur_nxt = state_r == ST_TFAULT && !seen_high_r;
		drun_nxt = state_r == ST_DETECT;
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			a_on_r <= 1'b0;
			b_on_r <= 1'b0;
			pg_r   <= 1'b0;
			pwm_r  <= 1'b0;
			fast_r <= 1'b0;
			dcur_r <= 1'b0;
			drun_r <= 1'b0;
		end else begin
			a_on_r <= a_on_nxt;
			b_on_r <= b_on_nxt;
			pg_r   <= pg_nxt;
			pwm_r  <= pwm_nxt;
			fast_r <= fast_nxt;
			dcur_r <= dcur_nxt;
			drun_r <= drun_nxt;
		end
	end

	// open-drain: enable low pulls the pin low
	assign STATUS_OUT_A_O      = 1'b0;
	assign STATUS_OUT_B_O      = 1'b0;
	assign POWER_GOOD_OUT_O    = 1'b0;
	assign STATUS_OUT_A_OE_N   = !a_on_r;
	assign STATUS_OUT_B_OE_N   = !b_on_r;
	assign POWER_GOOD_OUT_OE_N = !pg_r;
	assign PWM_EN              = pwm_r;
	assign RATE_FAST           = fast_r;
	assign DETECT_CURRENT_EN   = dcur_r;
	assign BAT_DETECT_RUN      = drun_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	a_sleep_pg_off: assert property (!vcc_s |-> ##2 POWER_GOOD_OUT_OE_N && !PWM_EN)
		else $error("supply loss did not stop charging");
	a_ce_idle: assert property (vcc_s && ce_n_s |=> state_r == ST_IDLE ##1 !PWM_EN)
		else $error("enable high did not stop charge");
	a_ovp_stop: assert property (vcc_s && !ce_n_s && ovp_s |-> ##2 !PWM_EN && STATUS_OUT_A_OE_N)
		else $error("overvoltage left switching on");
	a_ce_fall_clr: assert property (vcc_s && !ovp_s && ce_fall |=> timer_r == '0 && state_r != ST_TFAULT)
		else $error("enable toggle kept timer or fault");
	a_ttc_zero: assert property (ttc_rise |=> timer_r == '0)
		else $error("timer enable rise did not zero timer");
	a_term_done: assert property (vcc_s && !ce_n_s && !ovp_s && !ce_fall && !timeout && !ttc_rise
		&& state_r == ST_VREG && term_s && term_en |=> state_r == ST_DONE ##1 !STATUS_OUT_B_OE_N)
		else $error("termination did not complete charge");
	a_timeout_flt: assert property (vcc_s && !ce_n_s && !ovp_s && !ce_fall && !(ttc_rise && !host)
		&& timeout |=> state_r == ST_TFAULT)
		else $error("timer expiry not flagged");
	a_tfault_exit: assert property (vcc_s && !ce_n_s && !ovp_s && !ce_fall && state_r == ST_TFAULT
		&& seen_high_r && rch_s |=> state_r == ST_DETECT ##1 BAT_DETECT_RUN)
		else $error("fault recovery did not enter detection");
	a_detect_off: assert property (state_r == ST_TFAULT && !rch_s |-> ##2 !DETECT_CURRENT_EN)
		else $error("detect current left on above threshold");
	a_std_charge: assert property (!alt && charging && !suspend |=> !STATUS_OUT_A_OE_N && STATUS_OUT_B_OE_N)
		else $error("standard charging status wrong");
	a_alt_blink: assert property (alt && state_r == ST_TFAULT |=> STATUS_OUT_A_OE_N == !$past(blink_r)
		&& STATUS_OUT_B_OE_N)
		else $error("alternative fault status not blinking");
	a_blink_half: assert property ($changed(blink_r) |-> $past(tick_r)
		&& $past(half_cnt_r) == 16'(BLINK_HALF_TICKS - 1))
		else $error("blink toggled off its half period");
	a_host_vreg: assert property (host && vcc_s && !ce_n_s && !ovp_s && !ce_fall && state_r == ST_FAST
		&& at_vreg_s |=> state_r == ST_VREG ##1 RATE_FAST)
		else $error("host mode ignored regulation voltage");
	a_host_notimer: assert property (host |=> $stable(timer_r) || timer_r == '0)
		else $error("host mode ran safety timer");
endmodule
